// *** hw/adc_input_reference_select.sv ***
// Converter input, reference and result adjustment control
// Function
// - Low bits 00 supply, 01 external pin
// - Code 010 internal 1.1V, 011 reserved
// - Codes 110/111 internal 2.56V, 111 with capacitor
// - Reference change waits for conversion end
// - Reference change makes next conversion extended
// - Adjust bit chooses left or right presentation
// - Adjust change shows immediately, even mid-conversion
// - Six-bit code: singles, 1.1V and 0V
// - Fixed-gain pairs and offset same-pin pairs
// - Pair codes 100000-110111: even high gain, odd low
// - Code 111111 selects the temperature sensor
// - Gain select picks 32x/8x over 20x/1x
// - Channel change waits for conversion end
// - Normal 13 cycles, extended 25 cycles
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "adc_sel_params.svh"
module adc_input_reference_select
    import adc_sel_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic converter_enable,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic conv_busy,
    output logic conv_long,
    output logic [4:0] conv_cycles,
    output chan_kind_t chan_kind,
    output logic [3:0] pos_input,
    output logic [3:0] neg_input,
    output gain_t gain,
    output logic temp_sensor_en,
    output ref_src_t ref_source,
    output logic internal_ref_on,
    output logic ref_pin_connected,
    output logic ref_reserved
);

    // ****************************************************
    // Software registers
    // ****************************************************
    logic [7:0] select_q; // Channel/reference select register
    logic gain_sel_q; // Gain pair select
    logic ref_high_q; // Reference code high bit
    logic chan_ext_q; // Channel code extension bit
    logic [9:0] result_q; // Last conversion result
    logic [7:0] rdata_q; // Read data, one cycle after strobe

    // ****************************************************
    // Active selection and conversion state
    // ****************************************************
    logic [5:0] act_chan_q; // Channel code in use
    logic [2:0] act_ref_q; // Reference code in use
    logic busy_q; // Conversion in progress
    logic enable_q; // Enable seen last cycle
    logic extended_q; // Next conversion must run long
    logic long_q; // Running conversion is long
    logic [4:0] cycles_q; // Length of running conversion
    chan_kind_t kind_q;
    logic [3:0] pos_q;
    logic [3:0] neg_q;
    gain_t gain_q;
    logic temp_q;
    ref_src_t ref_src_q;
    logic int_on_q;
    logic pin_q;
    logic reserved_q;

    // ****************************************************
    // Combinational helpers
    // ****************************************************
    logic [5:0] sw_chan; // Channel code as software left it
    logic [2:0] sw_ref; // Reference code as software left it
    logic apply; // Pending codes may become active now
    logic ref_change; // Reference changes on this apply
    logic enable_rise; // Converter just switched on
    logic [7:0] data_low;
    logic [7:0] data_high;
    logic [7:0] read_mux;
    logic [7:0] status;
    chan_kind_t kind_d;
    logic [3:0] pos_d;
    logic [3:0] neg_d;
    gain_t gain_d;
    logic [8:0] pair;
    ref_src_t ref_src_d;
    logic int_on_d;
    logic pin_d;
    logic reserved_d;

    assign sw_chan = {chan_ext_q, select_q[`SEL_CHAN_HI:0]};
    assign sw_ref = {ref_high_q, select_q[`SEL_REF_MID:`SEL_REF_LOW]};
    // Hold back while busy; a start in this cycle counts as busy too
    assign apply = !converter_enable || conv_done
        || (!busy_q && !conv_start);
    assign ref_change = apply && (sw_ref != act_ref_q);
    assign enable_rise = converter_enable && !enable_q;

    // ****************************************************
    // Pair table: {positive, negative, high-gain}
    // ****************************************************
    // Pair codes repeat in even/odd couples, so index by code[4:1]
    function automatic logic [8:0] pair_lookup(input logic [5:0] c);
        logic [8:0] e;
        e = 9'h000;
        if (c >= `CH_PAIR_FIRST && c < `CH_OFFSET_FIRST)
        begin
            case (c[4:1])
                4'h0: e = 9'h002;
                4'h1: e = 9'h020;
                4'h2: e = 9'h024;
                4'h3: e = 9'h042;
                4'h4: e = 9'h040;
                4'h5: e = 9'h004;
                4'h6: e = 9'h08A;
                4'h7: e = 9'h0A8;
                4'h8: e = 9'h0AC;
                4'h9: e = 9'h0CA;
                4'hA: e = 9'h0C8;
                4'hB: e = 9'h08C;
                default: e = 9'h000;
            endcase
            e[0] = ~c[0];
        end
        else
        begin
            case (c)
                6'h0B: e = 9'h003;
                6'h0C: e = 9'h002;
                6'h0D: e = 9'h023;
                6'h0E: e = 9'h043;
                6'h0F: e = 9'h042;
                6'h10: e = 9'h046;
                6'h11: e = 9'h067;
                6'h12: e = 9'h087;
                6'h13: e = 9'h086;
                6'h14: e = 9'h08B;
                6'h15: e = 9'h08A;
                6'h16: e = 9'h0AB;
                6'h17: e = 9'h0CB;
                6'h18: e = 9'h0CA;
                6'h19: e = 9'h113;
                6'h1A: e = 9'h112;
                6'h1B: e = 9'h133;
                6'h1C: e = 9'h153;
                6'h1D: e = 9'h152;
                6'h38: e = 9'h001;
                6'h39: e = 9'h000;
                6'h3A: e = 9'h023;
                6'h3B: e = 9'h045;
                6'h3C: e = 9'h089;
                6'h3D: e = 9'h0AB;
                6'h3E: e = 9'h0CD;
                default: e = 9'h000;
            endcase
        end
        return e;
    endfunction

    // ****************************************************
    // Channel decode of the pending code
    // ****************************************************
    // Decoded ahead of apply so outputs move with the code
    always_comb
    begin
        pair = pair_lookup(sw_chan);
        kind_d = CH_DIFF;
        pos_d = pair[8:5];
        neg_d = pair[4:1];
        gain_d = pair[0] ? GAIN_20X : GAIN_1X;
        if (sw_chan <= `CH_LAST_SINGLE)
        begin
            kind_d = CH_SINGLE;
            pos_d = sw_chan[3:0];
            neg_d = 4'h0;
        end
        else if (sw_chan == `CH_FIXED_1V1)
        begin
            kind_d = CH_FIXED_1V1;
        end
        else if (sw_chan == `CH_FIXED_0V)
        begin
            kind_d = CH_FIXED_0V;
        end
        else if (sw_chan == `CH_TEMP)
        begin
            kind_d = CH_TEMP;
            pos_d = `TEMP_INPUT;
        end
        else if (sw_chan >= `CH_PAIR_FIRST)
        begin
            if (pair[0])
                gain_d = gain_sel_q ? GAIN_32X : GAIN_20X;
            else
                gain_d = gain_sel_q ? GAIN_8X : GAIN_1X;
        end
    end

    // Reference decode of the pending code
    reference_decode u_ref (
        .ref_code(sw_ref),
        .ref_source(ref_src_d),
        .internal_on(int_on_d),
        .pin_connected(pin_d),
        .reserved(reserved_d)
    );

    // Data bytes follow the live adjust bit, not a latched copy
    result_format u_fmt (
        .result(result_q),
        .left_adjust(select_q[`SEL_ADJUST]),
        .data_low(data_low),
        .data_high(data_high)
    );

    // ****************************************************
    // Register writes
    // ****************************************************
    // Unused bits of control register B are not kept
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            select_q <= `REG_RESET;
            gain_sel_q <= 1'b0;
            ref_high_q <= 1'b0;
            chan_ext_q <= 1'b0;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == `OFS_SELECT)
                select_q <= reg_wdata;
            if (reg_addr == `OFS_CTRL_B)
            begin
                gain_sel_q <= reg_wdata[`CB_GAIN_SEL];
                ref_high_q <= reg_wdata[`CB_REF_HIGH];
                chan_ext_q <= reg_wdata[`CB_CHAN_EXT];
            end
        end
    end

    // ****************************************************
    // Register reads
    // ****************************************************
    always_comb
    begin
        status = 8'h00;
        status[`ST_BUSY] = busy_q;
        status[`ST_EXTENDED] = extended_q;
        status[`ST_PENDING] = (sw_chan != act_chan_q)
            || (sw_ref != act_ref_q);
        status[`ST_REF_RESERVED] = reserved_q;
        case (reg_addr)
            `OFS_SELECT: read_mux = select_q;
            `OFS_CTRL_B: read_mux = {1'b0, gain_sel_q, 1'b0, ref_high_q,
                chan_ext_q, 3'h0};
            `OFS_DATA_LOW: read_mux = data_low;
            `OFS_DATA_HIGH: read_mux = data_high;
            `OFS_STATUS: read_mux = status;
            default: read_mux = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (srst)
            rdata_q <= 8'h00;
        else if (ce)
            rdata_q <= reg_rd ? read_mux : 8'h00;
    end

    // ****************************************************
    // Conversion tracking
    // ****************************************************
    // Switching off aborts the conversion in flight
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            busy_q <= 1'b0;
            enable_q <= 1'b0;
            result_q <= 10'h000;
        end
        else if (ce)
        begin
            enable_q <= converter_enable;
            if (!converter_enable)
                busy_q <= 1'b0;
            else if (conv_start)
                busy_q <= 1'b1;
            else if (conv_done)
                busy_q <= 1'b0;
            if (conv_done)
                result_q <= conv_result;
        end
    end

    // Extended flag: the start clear wins over a set from this cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            extended_q <= 1'b1;
            long_q <= 1'b0;
            cycles_q <= `CYC_NORMAL;
        end
        else if (ce)
        begin
            if (conv_start && converter_enable)
            begin
                // Change in this very cycle still counts for this start
                long_q <= extended_q || ref_change || enable_rise;
                cycles_q <= (extended_q || ref_change || enable_rise)
                    ? `CYC_EXTENDED : `CYC_NORMAL;
                extended_q <= 1'b0;
            end
            else if (ref_change || enable_rise)
                extended_q <= 1'b1;
        end
    end

    // ****************************************************
    // Active selection latch
    // ****************************************************
    // Decoded controls move with the codes so they never disagree
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            act_chan_q <= 6'h00;
            act_ref_q <= 3'h0;
            kind_q <= CH_SINGLE;
            pos_q <= 4'h0;
            neg_q <= 4'h0;
            gain_q <= GAIN_1X;
            temp_q <= 1'b0;
            ref_src_q <= REF_SUPPLY;
            int_on_q <= 1'b1;
            pin_q <= 1'b0;
            reserved_q <= 1'b0;
        end
        else if (ce && apply)
        begin
            act_chan_q <= sw_chan;
            act_ref_q <= sw_ref;
            kind_q <= kind_d;
            pos_q <= pos_d;
            neg_q <= neg_d;
            gain_q <= gain_d;
            temp_q <= (sw_chan == `CH_TEMP);
            ref_src_q <= ref_src_d;
            int_on_q <= int_on_d;
            pin_q <= pin_d;
            reserved_q <= reserved_d;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign reg_rdata = rdata_q;
    assign conv_busy = busy_q;
    assign conv_long = long_q;
    assign conv_cycles = cycles_q;
    assign chan_kind = kind_q;
    assign pos_input = pos_q;
    assign neg_input = neg_q;
    assign gain = gain_q;
    assign temp_sensor_en = temp_q;
    assign ref_source = ref_src_q;
    assign internal_ref_on = int_on_q;
    assign ref_pin_connected = pin_q;
    assign ref_reserved = reserved_q;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence seq_read_high_left;
        ce && reg_rd && reg_addr == `OFS_DATA_HIGH
            && select_q[`SEL_ADJUST];
    endsequence

    sequence seq_hold_mid_conv;
        ce && busy_q && converter_enable && !conv_done;
    endsequence

    chk_ref_supply: assert property (
        act_ref_q[1:0] == 2'b00 |-> ref_src_q == REF_SUPPLY)
        else $error("supply code not decoded to supply");
    chk_ref_ext_pin: assert property (
        act_ref_q[1:0] == 2'b01 |-> ref_src_q == REF_EXT_PIN && !int_on_q)
        else $error("external pin code wrong");
    chk_ref_reserved: assert property (
        act_ref_q == 3'b011 |-> reserved_q && ref_src_q == REF_RESERVED)
        else $error("reserved reference accepted");
    chk_ref_2v56: assert property (
        act_ref_q[2:1] == 2'b11 |-> int_on_q && pin_q == act_ref_q[0])
        else $error("2.56V reference pin state wrong");
    chk_hold_busy: assert property (
        seq_hold_mid_conv |=> $stable(act_ref_q) && $stable(act_chan_q))
        else $error("selection changed mid-conversion");
    chk_long_after_ref: assert property (
        ce && ref_change && !(conv_start && converter_enable)
            |=> extended_q)
        else $error("reference change did not mark extended");
    chk_conv_length: assert property (
        conv_long == (conv_cycles == `CYC_EXTENDED)
            && (conv_cycles == `CYC_EXTENDED
            || conv_cycles == `CYC_NORMAL))
        else $error("conversion length mismatch");
    chk_adjust_now: assert property (
        seq_read_high_left |=> reg_rdata == $past(result_q[9:2]))
        else $error("left adjusted high byte wrong");
    chk_single_end: assert property (
        act_chan_q <= `CH_LAST_SINGLE
            |-> kind_q == CH_SINGLE && pos_q == act_chan_q[3:0])
        else $error("single-ended decode wrong");
    chk_temp_sense: assert property (
        temp_q == (act_chan_q == `CH_TEMP) && (temp_q -> kind_q == CH_TEMP))
        else $error("temperature sensor select wrong");
    chk_gain_pair: assert property (
        ce && apply && sw_chan >= `CH_PAIR_FIRST && sw_chan < `CH_TEMP
            && sw_chan != `CH_OFFSET_LOW_GAIN && !sw_chan[0] && gain_sel_q
            |=> gain == GAIN_32X)
        else $error("high gain pair not 32x");
    chk_latch_done: assert property (
        ce && conv_done && converter_enable
            |=> act_chan_q == $past(sw_chan) && act_ref_q == $past(sw_ref))
        else $error("pending codes not latched at completion");

endmodule
`default_nettype wire

// *** hw/adc_sel_params.svh ***
// Constants for the converter input and reference selection block
`ifndef ADC_SEL_PARAMS_SVH
`define ADC_SEL_PARAMS_SVH

// ****************************************************
// Register map (index on the plain register port)
// ****************************************************
`define ADDR_W 3
`define OFS_SELECT 3'h0
`define OFS_CTRL_B 3'h1
`define OFS_DATA_LOW 3'h2
`define OFS_DATA_HIGH 3'h3
`define OFS_STATUS 3'h4
`define REG_RESET 8'h00

// ****************************************************
// Field positions
// ****************************************************
`define SEL_REF_MID 7
`define SEL_REF_LOW 6
`define SEL_ADJUST 5
`define SEL_CHAN_HI 4
`define CB_GAIN_SEL 6
`define CB_REF_HIGH 4
`define CB_CHAN_EXT 3
`define ST_BUSY 0
`define ST_EXTENDED 1
`define ST_PENDING 2
`define ST_REF_RESERVED 3

// ****************************************************
// Channel codes and conversion lengths
// ****************************************************
`define CH_LAST_SINGLE 6'h0A
`define CH_FIXED_1V1 6'h1E
`define CH_FIXED_0V 6'h1F
`define CH_PAIR_FIRST 6'h20
`define CH_OFFSET_FIRST 6'h38
`define CH_OFFSET_LOW_GAIN 6'h39
`define CH_TEMP 6'h3F
`define TEMP_INPUT 4'hB
`define CYC_NORMAL 5'h0D
`define CYC_EXTENDED 5'h19

`endif

// *** hw/adc_sel_pkg.sv ***
// Types shared by the converter selection block
package adc_sel_pkg;
    // Reference source driven to the analog reference circuits
    typedef enum logic [2:0] {
        REF_SUPPLY = 3'b000,
        REF_EXT_PIN = 3'b001,
        REF_INT_1V1 = 3'b010,
        REF_RESERVED = 3'b011,
        REF_INT_2V56 = 3'b100,
        REF_INT_2V56_CAP = 3'b101
    } ref_src_t;
    // Kind of input connected to the converter
    typedef enum logic [2:0] {
        CH_SINGLE = 3'b000,
        CH_DIFF = 3'b001,
        CH_FIXED_1V1 = 3'b010,
        CH_FIXED_0V = 3'b011,
        CH_TEMP = 3'b100
    } chan_kind_t;
    // Gain of the differential stage
    typedef enum logic [1:0] {
        GAIN_1X = 2'b00,
        GAIN_8X = 2'b01,
        GAIN_20X = 2'b10,
        GAIN_32X = 2'b11
    } gain_t;
endpackage

// *** hw/reference_decode.sv ***
// Decoder from the three-bit reference code to reference controls
`timescale 1ns/1ns
`default_nettype none
module reference_decode
    import adc_sel_pkg::*;
(
    input wire logic [2:0] ref_code,
    output ref_src_t ref_source,
    output logic internal_on,
    output logic pin_connected,
    output logic reserved
);
    // Low bits 00 and 01 ignore the high bit
    always_comb
    begin
        internal_on = 1'b1;
        pin_connected = 1'b0;
        reserved = 1'b0;
        case (ref_code)
            3'b000, 3'b100: ref_source = REF_SUPPLY;
            3'b001, 3'b101:
            begin
                ref_source = REF_EXT_PIN;
                internal_on = 1'b0;
                pin_connected = 1'b1;
            end
            3'b010: ref_source = REF_INT_1V1;
            3'b110: ref_source = REF_INT_2V56;
            3'b111:
            begin
                ref_source = REF_INT_2V56_CAP;
                pin_connected = 1'b1;
            end
            default:
            begin
                ref_source = REF_RESERVED;
                internal_on = 1'b0;
                reserved = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// *** hw/result_format.sv ***
// Presentation of the ten-bit result in the two data bytes
`timescale 1ns/1ns
`default_nettype none
module result_format (
    input wire logic [9:0] result,
    input wire logic left_adjust,
    output logic [7:0] data_low,
    output logic [7:0] data_high
);
    // Pure wiring, so a change of adjust shows at once
    always_comb
    begin
        if (left_adjust)
        begin
            data_high = result[9:2];
            data_low = {result[1:0], 6'h00};
        end
        else
        begin
            data_high = {6'h00, result[9:8]};
            data_low = result[7:0];
        end
    end
endmodule
`default_nettype wire

// *** bench/conv_engine_model.sv ***
// Behavioural conversion engine facing the selection block
`timescale 1ns/1ns
`default_nettype none
module conv_engine_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic conv_busy,
    input wire logic [4:0] conv_cycles,
    input wire logic [9:0] value,
    output logic conv_done,
    output logic [9:0] conv_result
);
    // Cycles spent in the running conversion
    logic [4:0] cnt_q;
    // ****************************************************
    // Conversion timing
    // ****************************************************
    // Count while busy, restart when idle
    always_ff @(posedge core_clk)
    begin
        if (srst || !conv_busy)
            cnt_q <= 5'h01;
        else
            cnt_q <= cnt_q + 5'h01;
    end
    // Done on the last cycle of the length that the block asked for
    assign conv_done = conv_busy && (cnt_q == conv_cycles);
    // Inverted outside done, so a late sample of stale data shows up
    assign conv_result = conv_done ? value : ~value;
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the converter selection block
`timescale 1ns/1ns
`default_nettype none
`include "adc_sel_params.svh"
module tb_top
    import adc_sel_pkg::*;
;
    // Clock, reset and bus drive
    logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic conv_start = 1'b0, conv_done, conv_busy, conv_long;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rv;
    logic [9:0] conv_result, value = 10'h000;
    logic [4:0] conv_cycles;
    logic [3:0] pos_input, neg_input;
    logic temp_sensor_en, en = 1'b1, int_on, pin_con, ref_res;
    chan_kind_t chan_kind;
    gain_t gain;
    ref_src_t ref_source, rexp;
    int n_fail = 0, checks_done = 0;
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    adc_input_reference_select adc_input_reference_select_i (
        .core_clk(core_clk), .srst(srst), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .converter_enable(en), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result),
        .conv_busy(conv_busy), .conv_long(conv_long),
        .conv_cycles(conv_cycles), .chan_kind(chan_kind),
        .pos_input(pos_input), .neg_input(neg_input), .gain(gain),
        .temp_sensor_en(temp_sensor_en), .ref_source(ref_source),
        .internal_ref_on(int_on), .ref_pin_connected(pin_con),
        .ref_reserved(ref_res));
    conv_engine_model conv_engine_model_i (
        .core_clk(core_clk), .srst(srst), .conv_busy(conv_busy),
        .conv_cycles(conv_cycles), .value(value),
        .conv_done(conv_done), .conv_result(conv_result));
    // ****************************************************
    // Bus and check tasks
    // ****************************************************
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // Start a conversion and check the length chosen for it
    task automatic start(input logic lng, input logic [9:0] r);
        @(posedge core_clk);
        conv_start <= 1'b1;
        value <= r;
        @(posedge core_clk);
        conv_start <= 0;
        #1 chk("long", 16'(lng), 16'(conv_long));
        chk("cycles", 16'(lng ? `CYC_EXTENDED : `CYC_NORMAL),
            16'(conv_cycles));
    endtask
    // Bounded wait for the end of a conversion
    task automatic idle();
        for (int i = 0; i < 40; i++)
        begin
            @(posedge core_clk);
            #1;
            if (conv_busy === 1'b0)
                return;
        end
        n_fail++;
        final_report();
    endtask
    // Channel code table entry: write, let it apply, compare
    task automatic tch(input logic [5:0] c, input logic g,
        input chan_kind_t k, input logic [3:0] p, n, input gain_t gn);
        wr(`OFS_CTRL_B, {1'b0, g, 2'b00, c[5], 3'b000});
        wr(`OFS_SELECT, {3'b000, c[4:0]});
        settle();
        chk("kind", 16'(k), 16'(chan_kind));
        chk("temp", 16'(k == CH_TEMP), 16'(temp_sensor_en));
        if (k == CH_SINGLE || k == CH_TEMP || k == CH_DIFF)
            chk("pos", 16'(p), 16'(pos_input));
        if (k == CH_DIFF)
        begin
            chk("neg", 16'(n), 16'(neg_input));
            chk("gain", 16'(gn), 16'(gain));
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        rd(`OFS_SELECT);
        chk("select", 16'h0000, 16'(rv));
        rd(3'h5);
        chk("unmapped", 16'h0000, 16'(rv));
        start(1'b1, 10'h001);
        idle();
        start(1'b0, 10'h002);
        idle();
        // Every reference code, written while idle
        for (int i = 0; i < 8; i++)
        begin
            wr(`OFS_CTRL_B, {3'h0, i[2], 4'h0});
            wr(`OFS_SELECT, {i[1:0], 6'h00});
            settle();
            case (i[1:0])
                2'b00: rexp = REF_SUPPLY;
                2'b01: rexp = REF_EXT_PIN;
                2'b10: rexp = i[2] ? REF_INT_2V56 : REF_INT_1V1;
                default: rexp = i[2] ? REF_INT_2V56_CAP : REF_RESERVED;
            endcase
            chk("ref", 16'(rexp), 16'(ref_source));
            chk("int on", 16'(i[1:0] != 2'b01 && i[2:0] != 3'b011),
                16'(int_on));
            chk("pin", 16'(i[1:0] == 2'b01 || i[2:0] == 3'b111),
                16'(pin_con));
            chk("reserved", 16'(i[2:0] == 3'b011), 16'(ref_res));
        end
        tch(6'h0A, 1'b0, CH_SINGLE, 4'hA, 4'h0, GAIN_1X);
        tch(6'h1E, 1'b0, CH_FIXED_1V1, 4'h0, 4'h0, GAIN_1X);
        tch(6'h1F, 1'b0, CH_FIXED_0V, 4'h0, 4'h0, GAIN_1X);
        tch(6'h3F, 1'b0, CH_TEMP, 4'hB, 4'h0, GAIN_1X);
        tch(6'h0B, 1'b0, CH_DIFF, 4'h0, 4'h1, GAIN_20X);
        tch(6'h0C, 1'b1, CH_DIFF, 4'h0, 4'h1, GAIN_1X);
        tch(6'h1D, 1'b0, CH_DIFF, 4'hA, 4'h9, GAIN_1X);
        tch(6'h20, 1'b0, CH_DIFF, 4'h0, 4'h1, GAIN_20X);
        tch(6'h20, 1'b1, CH_DIFF, 4'h0, 4'h1, GAIN_32X);
        tch(6'h23, 1'b1, CH_DIFF, 4'h1, 4'h0, GAIN_8X);
        tch(6'h37, 1'b0, CH_DIFF, 4'h4, 4'h6, GAIN_1X);
        tch(6'h3E, 1'b0, CH_DIFF, 4'h6, 4'h6, GAIN_20X);
        // Reference moved since the last conversion
        start(1'b1, 10'h2A5);
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_SELECT, 8'h85);
        settle();
        chk("ref held", 16'(REF_SUPPLY), 16'(ref_source));
        chk("chan held", 16'(CH_DIFF), 16'(chan_kind));
        idle();
        chk("ref applied", 16'(REF_INT_1V1), 16'(ref_source));
        chk("chan applied", 16'(CH_SINGLE), 16'(chan_kind));
        chk("pos applied", 16'h0005, 16'(pos_input));
        // Model results ignore the reference, so no settling wait is kept
        rd(`OFS_DATA_LOW);
        chk("low right", 16'h00A5, 16'(rv));
        rd(`OFS_DATA_HIGH);
        chk("high right", 16'h0002, 16'(rv));
        start(1'b1, 10'h155);
        wr(`OFS_SELECT, 8'hA5);
        rd(`OFS_DATA_HIGH);
        chk("high left", 16'h00A9, 16'(rv));
        rd(`OFS_DATA_LOW);
        chk("low left", 16'h0040, 16'(rv));
        idle();
        rd(`OFS_DATA_HIGH);
        chk("high new", 16'h0055, 16'(rv));
        // Adjust is not a reference change, so this one is short
        start(1'b0, 10'h000);
        idle();
        // Off, new channel only, on again: the restart alone makes it long
        @(posedge core_clk);
        en <= 1'b0;
        wr(`OFS_SELECT, 8'hA6);
        en <= 1'b1;
        start(1'b1, 10'h000);
        idle();
        chk("pos restart", 16'h0006, 16'(pos_input));
        final_report();
    end
endmodule
`default_nettype wire
